/* File: pkg/drp_toggle_pkg.sv */
// constants and types for the dual-role toggle offload block
package drp_toggle_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTL       = 12'h0890;
  localparam logic [11:0] IDX_SEED      = 12'h0892;
  localparam logic [11:0] IDX_PERIOD    = 12'h0894;
  localparam logic [11:0] IDX_DBG       = 12'h0896;
  localparam logic [11:0] IDX_DBG_HI    = 12'h0897;
  localparam logic [11:0] IDX_SNK_MATCH = 12'h0898;
  localparam logic [11:0] IDX_SRC_MATCH = 12'h0899;
  localparam logic [11:0] IDX_SNK_DBCLR = 12'h089a;
  localparam logic [11:0] IDX_SRC_DBCLR = 12'h089b;
  localparam logic [11:0] IDX_BIAS      = 12'h089c;
  localparam logic [11:0] IDX_SNK_SAMP  = 12'h089d;
  localparam logic [11:0] IDX_SRC_SAMP  = 12'h089e;
  // control register fields
  localparam int CTL_EN_BIT    = 0;
  localparam int CTL_RND_BIT   = 1;
  localparam int CTL_INIT_BIT  = 7;
  localparam int CTL_STATE_BIT = 8;
  // reset values
  localparam logic [15:0] SEED_RST   = 16'hffff;
  localparam logic [7:0]  PERIOD_RST = 8'h40;
  localparam logic [15:0] DBG_RST    = 16'h0000;
  localparam logic [7:0]  MASK_RST   = 8'h00;
  localparam logic [7:0]  SAMP_RST   = 8'hff;
  localparam logic [2:0]  BIAS_RST   = 3'h0;
  // timing: 125 MHz core clock, 10 kHz generator and timer tick
  localparam int CLK_HZ        = 32'h0773_5940;
  localparam int RAND_HZ       = 32'h0000_2710;
  localparam int RAND_TICK_CYC = CLK_HZ / RAND_HZ;
  localparam int PERIOD_UNIT_HZ = 32'h0000_03e8;
  localparam int TICKS_PER_MS  = RAND_HZ / PERIOD_UNIT_HZ;
  // period limits in ms and bias split, parts of 64
  localparam logic [7:0] PERIOD_MIN = 8'h32;
  localparam logic [7:0] PERIOD_MAX = 8'h64;
  localparam logic [6:0] BIAS_DEN   = 7'h40;
  localparam logic [6:0] NUM_EVEN   = 7'h20;
  localparam logic [6:0] NUM_B100   = 7'h24;
  localparam logic [6:0] NUM_B101   = 7'h29;
  localparam logic [6:0] NUM_B110   = 7'h1c;
  localparam logic [6:0] NUM_B111   = 7'h17;
  typedef enum logic [1:0] {ST_IDLE, ST_DFP, ST_UFP} role_state_t;
endpackage

/* File: hw/drp_toggle.sv */
// dual-role toggle offload: role timer, randomiser, role masks, wishbone slave
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module drp_toggle #(
  parameter int TICK_CYC = drp_toggle_pkg::RAND_TICK_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [13:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // one-time-programmable seed
  input  wire logic [15:0] otp_seed,
  input  wire logic        otp_programmed,
  // per-CC logic
  input  wire logic [7:0]  cc1_change_status,
  input  wire logic [7:0]  cc2_change_status,
  input  wire logic [7:0]  cc_sample_enable_sw,
  input  wire logic [7:0]  cc_debounce_clear_enable_sw,
  output logic      [7:0]  cc_sample_enable,
  output logic      [7:0]  cc_debounce_clear_enable,
  output logic             cc_first_match_change_irq,
  output logic             cc_second_match_change_irq,
  // advertised role
  output logic             advertised_role,
  output logic             toggle_active
);

  typedef struct packed {
    logic                        ack;
    logic [31:0]                 dat;
    logic                        ctl_en;
    logic                        ctl_rnd;
    logic                        ctl_init;
    logic                        rnd_prev;
    logic [15:0]                 seed;
    logic                        seed_loaded;
    logic [7:0]                  period;
    logic [15:0]                 lfsr;
    logic [7:0]                  snap_hi;
    logic [7:0]                  snk_match;
    logic [7:0]                  src_match;
    logic [7:0]                  snk_dbclr;
    logic [7:0]                  src_dbclr;
    logic [2:0]                  bias;
    logic [7:0]                  snk_samp;
    logic [7:0]                  src_samp;
    drp_toggle_pkg::role_state_t st;
    logic                        second;
    logic [15:0]                 pre;
    logic                        tick;
    logic [11:0]                 cnt;
    logic                        irq1;
    logic                        irq2;
    logic [7:0]                  samp;
    logic [7:0]                  dbclr;
    logic                        role;
    logic                        active;
  } state_t;

  state_t r_reg;
  state_t r_next;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

  // dfp share of 64 for a bias code
  function automatic logic [6:0] dfp_num(input logic [2:0] b);
    logic [6:0] n;
    n = drp_toggle_pkg::NUM_EVEN;
    case (b)
      3'h4:    n = drp_toggle_pkg::NUM_B100;
      3'h5:    n = drp_toggle_pkg::NUM_B101;
      3'h6:    n = drp_toggle_pkg::NUM_B110;
      3'h7:    n = drp_toggle_pkg::NUM_B111;
      default: n = drp_toggle_pkg::NUM_EVEN;
    endcase
    return n;
  endfunction

  // phase length in 0.1 ms ticks, rounded, never zero
  function automatic logic [11:0] phase_ticks(input logic [7:0] per, input logic [6:0] num);
    logic [19:0] p;
    p = 20'(per) * 20'(num) * 20'(drp_toggle_pkg::TICKS_PER_MS) + 20'h0_0020;
    return (p[17:6] == 12'h000) ? 12'h001 : p[17:6];
  endfunction

  // random period folded into 50..100 ms
  function automatic logic [7:0] rand_period(input logic [15:0] s);
    logic [7:0] v;
    v = {2'b00, s[5:0]};
    if (v > 8'h32)
      v = v - 8'h0d;
    return drp_toggle_pkg::PERIOD_MIN + v;
  endfunction

  // x^16 + x^15 + x^13 + x^4 + 1; an all-zero seed locks the generator
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]};
  endfunction

  logic        req;
  logic        wr;
  logic [11:0] idx;
  logic [6:0]  num;
  logic [11:0] target;
  logic        init_role;

  assign req = cyc_i && stb_i && !r_reg.ack;
  assign wr  = req && we_i;
  assign idx = adr_i[13:2];

  always_comb
  begin
    r_next = r_reg;
    init_role = r_reg.ctl_init;
    // bus handshake: one wait state, ack for one cycle
    r_next.ack = req;
    r_next.dat = 32'h0000_0000;
    if (req && !we_i)
    begin
      case (idx)
        drp_toggle_pkg::IDX_CTL:
        begin
          r_next.dat[drp_toggle_pkg::CTL_EN_BIT]    = r_reg.ctl_en;
          r_next.dat[drp_toggle_pkg::CTL_RND_BIT]   = r_reg.ctl_rnd;
          r_next.dat[drp_toggle_pkg::CTL_INIT_BIT]  = r_reg.ctl_init;
          r_next.dat[drp_toggle_pkg::CTL_STATE_BIT] = r_reg.role;
        end
        drp_toggle_pkg::IDX_SEED:      r_next.dat[15:0] = r_reg.seed;
        drp_toggle_pkg::IDX_PERIOD:    r_next.dat[7:0] = r_reg.period;
        drp_toggle_pkg::IDX_DBG:
        begin
          r_next.dat[15:0] = r_reg.lfsr;
          r_next.snap_hi = r_reg.lfsr[15:8];
        end
        drp_toggle_pkg::IDX_DBG_HI:    r_next.dat[7:0] = r_reg.snap_hi;
        drp_toggle_pkg::IDX_SNK_MATCH: r_next.dat[7:0] = r_reg.snk_match;
        drp_toggle_pkg::IDX_SRC_MATCH: r_next.dat[7:0] = r_reg.src_match;
        drp_toggle_pkg::IDX_SNK_DBCLR: r_next.dat[7:0] = r_reg.snk_dbclr;
        drp_toggle_pkg::IDX_SRC_DBCLR: r_next.dat[7:0] = r_reg.src_dbclr;
        drp_toggle_pkg::IDX_BIAS:      r_next.dat[2:0] = r_reg.bias;
        drp_toggle_pkg::IDX_SNK_SAMP:  r_next.dat[7:0] = r_reg.snk_samp;
        drp_toggle_pkg::IDX_SRC_SAMP:  r_next.dat[7:0] = r_reg.src_samp;
        default:                       r_next.dat = 32'h0000_0000;
      endcase
    end
    // otp seed taken once after reset release
    if (!r_reg.seed_loaded)
    begin
      r_next.seed_loaded = 1'b1;
      if (otp_programmed)
        r_next.seed = otp_seed;
    end
    if (wr)
    begin
      case (idx)
        drp_toggle_pkg::IDX_CTL:
        begin
          if (sel_i[0])
          begin
            r_next.ctl_en   = dat_i[drp_toggle_pkg::CTL_EN_BIT];
            r_next.ctl_rnd  = dat_i[drp_toggle_pkg::CTL_RND_BIT];
            r_next.ctl_init = dat_i[drp_toggle_pkg::CTL_INIT_BIT];
          end
        end
        drp_toggle_pkg::IDX_SEED:
        begin
          if (sel_i[0])
            r_next.seed[7:0] = dat_i[7:0];
          if (sel_i[1])
            r_next.seed[15:8] = dat_i[15:8];
        end
        drp_toggle_pkg::IDX_PERIOD:    if (sel_i[0]) r_next.period = dat_i[7:0];
        drp_toggle_pkg::IDX_SNK_MATCH: if (sel_i[0]) r_next.snk_match = dat_i[7:0];
        drp_toggle_pkg::IDX_SRC_MATCH: if (sel_i[0]) r_next.src_match = dat_i[7:0];
        drp_toggle_pkg::IDX_SNK_DBCLR: if (sel_i[0]) r_next.snk_dbclr = dat_i[7:0];
        drp_toggle_pkg::IDX_SRC_DBCLR: if (sel_i[0]) r_next.src_dbclr = dat_i[7:0];
        drp_toggle_pkg::IDX_BIAS:      if (sel_i[0]) r_next.bias = dat_i[2:0];
        drp_toggle_pkg::IDX_SNK_SAMP:  if (sel_i[0]) r_next.snk_samp = dat_i[7:0];
        drp_toggle_pkg::IDX_SRC_SAMP:  if (sel_i[0]) r_next.src_samp = dat_i[7:0];
        default:                       r_next.dat = 32'h0000_0000;
      endcase
    end
    // free-running 10 kHz prescaler
    if (r_reg.pre == TICK_LAST)
    begin
      r_next.pre  = 16'h0000;
      r_next.tick = 1'b1;
    end
    else
    begin
      r_next.pre  = r_reg.pre + 16'h0001;
      r_next.tick = 1'b0;
    end
    // generator
    r_next.rnd_prev = r_reg.ctl_rnd;
    if (r_reg.ctl_rnd && !r_reg.rnd_prev)
      r_next.lfsr = r_reg.seed;
    else if (r_reg.ctl_rnd && r_reg.tick)
      r_next.lfsr = lfsr_step(r_reg.lfsr);
    // role timer; hardware period update wins over a bus write
    num = dfp_num(r_reg.bias);
    if (r_reg.st == drp_toggle_pkg::ST_UFP)
      num = drp_toggle_pkg::BIAS_DEN - num;
    target = phase_ticks(r_reg.period, num);
    if (!r_reg.ctl_en)
    begin
      r_next.st     = drp_toggle_pkg::ST_IDLE;
      r_next.second = 1'b0;
      r_next.cnt    = 12'h000;
    end
    else
    begin
      case (r_reg.st)
        drp_toggle_pkg::ST_IDLE:
        begin
          r_next.st = init_role ? drp_toggle_pkg::ST_UFP : drp_toggle_pkg::ST_DFP;
          r_next.second = 1'b0;
          r_next.cnt = 12'h000;
          if (r_reg.ctl_rnd)
            r_next.period = rand_period(r_reg.lfsr);
        end
        drp_toggle_pkg::ST_DFP, drp_toggle_pkg::ST_UFP:
        begin
          if (r_reg.tick)
          begin
            if (r_reg.cnt + 12'h001 >= target)
            begin
              r_next.cnt = 12'h000;
              if (r_reg.second)
              begin
                r_next.second = 1'b0;
                r_next.st = init_role ? drp_toggle_pkg::ST_UFP : drp_toggle_pkg::ST_DFP;
                if (r_reg.ctl_rnd)
                  r_next.period = rand_period(r_reg.lfsr);
              end
              else
              begin
                r_next.second = 1'b1;
                r_next.st = (r_reg.st == drp_toggle_pkg::ST_DFP) ? drp_toggle_pkg::ST_UFP
                                                                  : drp_toggle_pkg::ST_DFP;
              end
            end
            else
              r_next.cnt = r_reg.cnt + 12'h001;
          end
        end
        default:
          r_next.st = drp_toggle_pkg::ST_IDLE;
      endcase
    end
    // role-selected masks, registered for clean outputs
    r_next.role   = (r_next.st == drp_toggle_pkg::ST_UFP);
    r_next.active = (r_reg.st != drp_toggle_pkg::ST_IDLE);
    if (r_reg.st == drp_toggle_pkg::ST_UFP)
    begin
      r_next.irq1  = |(cc1_change_status & r_reg.snk_match);
      r_next.irq2  = |(cc2_change_status & r_reg.snk_match);
      r_next.dbclr = r_reg.snk_dbclr;
      r_next.samp  = r_reg.snk_samp;
    end
    else if (r_reg.st == drp_toggle_pkg::ST_DFP)
    begin
      r_next.irq1  = |(cc1_change_status & r_reg.src_match);
      r_next.irq2  = |(cc2_change_status & r_reg.src_match);
      r_next.dbclr = r_reg.src_dbclr;
      r_next.samp  = r_reg.src_samp;
    end
    else
    begin
      // outside toggling the per-CC logic owns these paths
      r_next.irq1  = 1'b0;
      r_next.irq2  = 1'b0;
      r_next.dbclr = cc_debounce_clear_enable_sw;
      r_next.samp  = cc_sample_enable_sw;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      r_reg           <= '0;
      r_reg.st        <= drp_toggle_pkg::ST_IDLE;
      r_reg.seed      <= drp_toggle_pkg::SEED_RST;
      r_reg.period    <= drp_toggle_pkg::PERIOD_RST;
      r_reg.lfsr      <= drp_toggle_pkg::DBG_RST;
      r_reg.snk_match <= drp_toggle_pkg::MASK_RST;
      r_reg.src_match <= drp_toggle_pkg::MASK_RST;
      r_reg.snk_dbclr <= drp_toggle_pkg::MASK_RST;
      r_reg.src_dbclr <= drp_toggle_pkg::MASK_RST;
      r_reg.bias      <= drp_toggle_pkg::BIAS_RST;
      r_reg.snk_samp  <= drp_toggle_pkg::SAMP_RST;
      r_reg.src_samp  <= drp_toggle_pkg::SAMP_RST;
      r_reg.samp      <= drp_toggle_pkg::SAMP_RST;
    end
    else
      r_reg <= r_next;
  end

  assign dat_o                      = r_reg.dat;
  assign ack_o                      = r_reg.ack;
  assign cc_sample_enable           = r_reg.samp;
  assign cc_debounce_clear_enable   = r_reg.dbclr;
  assign cc_first_match_change_irq  = r_reg.irq1;
  assign cc_second_match_change_irq = r_reg.irq2;
  assign advertised_role            = r_reg.role;
  assign toggle_active              = r_reg.active;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_off_idle;
    !r_reg.ctl_en |=> r_reg.st == drp_toggle_pkg::ST_IDLE ##1 !toggle_active;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("toggling while disabled");

  property p_lfsr_step;
    r_reg.ctl_rnd && r_reg.rnd_prev && r_reg.tick |=> r_reg.lfsr == lfsr_step($past(r_reg.lfsr));
  endproperty
  a_lfsr_step: assert property (p_lfsr_step) else $error("generator did not step");

  property p_lfsr_hold;
    (r_reg.rnd_prev && !r_reg.tick) || !r_reg.ctl_rnd |=> $stable(r_reg.lfsr);
  endproperty
  a_lfsr_hold: assert property (p_lfsr_hold) else $error("generator moved off tick");

  property p_start_role;
    r_reg.ctl_en && r_reg.st == drp_toggle_pkg::ST_IDLE |=> advertised_role == $past(r_reg.ctl_init);
  endproperty
  a_start_role: assert property (p_start_role) else $error("wrong initial role");

  property p_seed_load;
    r_reg.ctl_rnd && !r_reg.rnd_prev |=> r_reg.lfsr == $past(r_reg.seed);
  endproperty
  a_seed_load: assert property (p_seed_load) else $error("seed not loaded");

  property p_otp_seed;
    !r_reg.seed_loaded && otp_programmed && !wr |=> r_reg.seed == $past(otp_seed);
  endproperty
  a_otp_seed: assert property (p_otp_seed) else $error("otp seed not taken");

  property p_snapshot;
    req && !we_i && idx == drp_toggle_pkg::IDX_DBG |=> r_reg.snap_hi == $past(r_reg.lfsr[15:8]);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("snapshot missed");

  property p_static_period;
    !r_reg.ctl_rnd && !(wr && idx == drp_toggle_pkg::IDX_PERIOD) |=> $stable(r_reg.period);
  endproperty
  a_static_period: assert property (p_static_period) else $error("period changed");

  property p_rand_range;
    r_reg.ctl_rnd && r_reg.ctl_en && r_reg.st == drp_toggle_pkg::ST_IDLE |=>
      r_reg.period >= drp_toggle_pkg::PERIOD_MIN && r_reg.period <= drp_toggle_pkg::PERIOD_MAX;
  endproperty
  a_rand_range: assert property (p_rand_range) else $error("random period out of range");

  property p_sink_irq;
    r_reg.st == drp_toggle_pkg::ST_UFP |=> cc_first_match_change_irq == |($past(cc1_change_status & r_reg.snk_match));
  endproperty
  a_sink_irq: assert property (p_sink_irq) else $error("sink irq gating wrong");

  property p_src_samp;
    r_reg.st == drp_toggle_pkg::ST_DFP |=> cc_sample_enable == $past(r_reg.src_samp);
  endproperty
  a_src_samp: assert property (p_src_samp) else $error("source sample mask wrong");

  c_toggle: cover property (advertised_role ##1 !advertised_role);
  c_rand:   cover property (r_reg.ctl_rnd && r_reg.tick ##1 r_reg.ctl_en);
  c_irq:    cover property (cc_second_match_change_irq && toggle_active);

endmodule

/* File: bench/cc_partner.sv */
// attached port partner model: change status seen per advertised role
`timescale 1ns/1ps
module cc_partner (
  // role seen on the pins
  input  wire logic       advertised_role,
  input  wire logic       toggle_active,
  // change status toward the block
  output logic      [7:0] cc1_change_status,
  output logic      [7:0] cc2_change_status
);
  // all ones while idle, so gating outside toggling shows
  always_comb
  begin
    if (!toggle_active)
    begin
      cc1_change_status = 8'hff;
      cc2_change_status = 8'hff;
    end
    else if (advertised_role)
    begin
      cc1_change_status = 8'h80;
      cc2_change_status = 8'h02;
    end
    else
    begin
      cc1_change_status = 8'h20;
      cc2_change_status = 8'h0c;
    end
  end
endmodule

/* File: bench/dual_role_toggle_offload_bench.sv */
// self-checking bench for the dual-role toggle offload block
`timescale 1ns/1ps
module dual_role_toggle_offload_bench;
  localparam int TICK = 8;
  localparam logic [7:0] WR [7] = '{8'h0f, 8'hf0, 8'h33, 8'hcc, 8'h04, 8'h3c, 8'hc3};
  localparam logic [7:0] RST [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
  localparam logic [7:0] BC [6] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
  localparam int NUM [6] = '{32, 32, 36, 41, 28, 23};
  logic        clk;
  logic        reset_n;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [13:0] adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [15:0] otp_seed;
  logic        otp_programmed;
  logic [7:0]  cc1_st;
  logic [7:0]  cc2_st;
  logic [7:0]  samp_out;
  logic [7:0]  dbclr_out;
  logic        irq1;
  logic        irq2;
  logic        role;
  logic        active;
  logic        act_q;
  logic        role_q;
  logic [31:0] rd;
  logic [15:0] s;
  int          fails;
  int          comparisons;
  int          t_now;
  int          t_act;
  int          t_up;
  int          t_dn;

  drp_toggle #(.TICK_CYC(TICK)) uut (
    .clk(clk), .reset_n(reset_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .otp_seed(otp_seed),
    .otp_programmed(otp_programmed), .cc1_change_status(cc1_st), .cc2_change_status(cc2_st),
    .cc_sample_enable_sw(8'h5a), .cc_debounce_clear_enable_sw(8'ha5),
    .cc_sample_enable(samp_out), .cc_debounce_clear_enable(dbclr_out),
    .cc_first_match_change_irq(irq1), .cc_second_match_change_irq(irq2),
    .advertised_role(role), .toggle_active(active));

  cc_partner partner (.advertised_role(role), .toggle_active(active),
    .cc1_change_status(cc1_st), .cc2_change_status(cc2_st));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // edge times of the role outputs; also the hang limit
  always @(posedge clk)
  begin
    t_now <= t_now + 1;
    act_q <= active;
    role_q <= role;
    if (active && !act_q)
      t_act <= t_now;
    if (role && !role_q)
      t_up <= t_now;
    if (!role && role_q)
      t_dn <= t_now;
    if (t_now == 60000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic conclude;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    comparisons++;
    if ((^got === 1'bx) || got < lo || got > hi)
    begin
      fails++;
      $display("BAD %0t %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // one classic cycle; read data taken at the ack edge; a hang ends at the bench timeout
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'hf;
    dat_i <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic pins(input logic [7:0] sm, input logic [7:0] dm, input logic i1, input logic i2);
    chk({16'h0000, samp_out, dbclr_out}, {16'h0000, sm, dm});
    chk({30'h0000_0000, irq1, irq2}, {30'h0000_0000, i1, i2});
  endtask

  // phase length window in clocks for a 50 ms period
  task automatic span(input int got, input int num);
    int n;
    n = (500 * num + 32) / 64;
    chk_in(got, (n - 1) * TICK, n * TICK + 2);
  endtask

  // no local limit: a role that never comes runs into the bench timeout
  task automatic wait_role(input logic v);
    while (role !== v)
    begin
      @(posedge clk);
    end
  endtask

  function automatic logic [15:0] step(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[14] ^ x[12] ^ x[3]};
  endfunction

  initial
  begin
    reset_n = 1'b0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 14'h0000;
    sel_i = 4'h0;
    dat_i = 32'h0000_0000;
    otp_seed = 16'h1357;
    otp_programmed = 1'b0;
    fails = 0;
    comparisons = 0;
    t_now = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rchk(drp_toggle_pkg::IDX_SEED, 32'h0000_ffff);
    rchk(drp_toggle_pkg::IDX_PERIOD, 32'h0000_0040);
    rchk(drp_toggle_pkg::IDX_DBG, 32'h0000_0000);
    for (int k = 0; k < 7; k++)
      rchk(12'(drp_toggle_pkg::IDX_SNK_MATCH + k), {24'h0, RST[k]});
    bus(1'b1, drp_toggle_pkg::IDX_CTL, 32'h0000_0100);
    rchk(drp_toggle_pkg::IDX_CTL, 32'h0000_0000);
    bus(1'b1, 12'h08a0, 32'h0000_00ff);
    rchk(12'h08a0, 32'h0000_0000);
    repeat (20) @(posedge clk);
    pins(8'h5a, 8'ha5, 1'b0, 1'b0);
    chk({30'h0, role, active}, 32'h0000_0000);
    for (int k = 0; k < 7; k++)
      bus(1'b1, 12'(drp_toggle_pkg::IDX_SNK_MATCH + k), {24'h0, WR[k]});
    for (int k = 0; k < 7; k++)
      rchk(12'(drp_toggle_pkg::IDX_SNK_MATCH + k), {24'h0, WR[k]});
    // software keeps the period at the low legal end
    bus(1'b1, drp_toggle_pkg::IDX_PERIOD, 32'h0000_0032);
    for (int k = 0; k < 6; k++)
    begin
      bus(1'b1, drp_toggle_pkg::IDX_BIAS, {24'h0, BC[k]});
      bus(1'b1, drp_toggle_pkg::IDX_CTL, 32'h0000_0001);
      wait_role(1'b1);
      repeat (10) @(posedge clk);
      pins(8'h3c, 8'h33, 1'b0, 1'b1);
      rchk(drp_toggle_pkg::IDX_CTL, 32'h0000_0101);
      wait_role(1'b0);
      repeat (10) @(posedge clk);
      pins(8'hc3, 8'hcc, 1'b1, 1'b0);
      rchk(drp_toggle_pkg::IDX_CTL, 32'h0000_0001);
      rchk(drp_toggle_pkg::IDX_PERIOD, 32'h0000_0032);
      span(t_up - t_act, NUM[k]);
      span(t_dn - t_up, 64 - NUM[k]);
      bus(1'b1, drp_toggle_pkg::IDX_CTL, 32'h0000_0000);
    end
    bus(1'b1, drp_toggle_pkg::IDX_CTL, 32'h0000_0081);
    wait_role(1'b1);
    repeat (2) @(posedge clk);
    // role follows the state at once, active one cycle later
    chk_in(t_act - t_up, 0, 1);
    bus(1'b1, drp_toggle_pkg::IDX_CTL, 32'h0000_0000);
    bus(1'b1, drp_toggle_pkg::IDX_SEED, 32'h0000_ace1);
    bus(1'b1, drp_toggle_pkg::IDX_CTL, 32'h0000_0003);
    bus(1'b0, drp_toggle_pkg::IDX_DBG, 32'h0000_0000);
    s = 16'hace1;
    chk({31'h0, rd === {16'h0, s} || rd === {16'h0, step(s)} || rd === {16'h0, step(step(s))}}, 32'h1);
    bus(1'b0, drp_toggle_pkg::IDX_PERIOD, 32'h0000_0000);
    chk_in(rd, 32'd50, 32'd100);
    bus(1'b0, drp_toggle_pkg::IDX_DBG, 32'h0000_0000);
    s = rd[15:0];
    // two low reads taken exactly ten generator ticks apart
    repeat (10 * TICK - 3) @(posedge clk);
    for (int k = 0; k < 10; k++)
      s = step(s);
    rchk(drp_toggle_pkg::IDX_DBG, {16'h0000, s});
    rchk(drp_toggle_pkg::IDX_DBG_HI, {24'h0, s[15:8]});
    reset_n <= 1'b0;
    otp_programmed <= 1'b1;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rchk(drp_toggle_pkg::IDX_SEED, 32'h0000_1357);
    rchk(drp_toggle_pkg::IDX_DBG, 32'h0000_0000);
    conclude();
  end
endmodule
